// ### core/sps_stepper_phase_sequencer.sv
// Notes on behaviour
// RULE1 - Five resolutions: 64, 32, 16, 8, 4 steps
// RULE2 - One position source chosen by select bit
// RULE3 - New position applies from next PWM period
// RULE4 - Select high: host writes to position ignored
// RULE5 - Step edge adds or subtracts resolution increment
// RULE6 - Aux function 01: pin picks alternate resolution
// RULE7 - Increment 1 for code 000, 2 for 001
// RULE8 - Increment 4 for code 010, 8 for 100
// RULE9 - Coarser resolution snaps position to nearest valid
// RULE10 - Select low: step pin ignored entirely
// RULE11 - Host computes positions when driving by writes
// RULE12 - Resolution change applies after next position update
// RULE13 - Enable low: standby, everything held at default
// RULE14 - Active only after start-up time elapses
// RULE15 - Position frozen while stall and hold-on-stall
// RULE16 - Direction bit chooses add or subtract
// RULE17 - Position wraps modulo 64
// RULE18 - Step pin synchronised, one update per edge
`timescale 1ns/100ps
`include "sps_defines.svh"

module sps_stepper_phase_sequencer #(
    parameter int START_CYCLES = `SPS_START_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic enable_i,
    input wire logic step_pulse_pin_i,
    input wire logic aux_input_pin_i,
    input wire logic pwm_period_start_i,
    input wire sps_pkg::sps_cfg_type cfg_i,
    input wire sps_pkg::sps_pos_write_type pos_write_i,
    output logic active_o,
    output logic [5:0] step_position_o,
    output logic [5:0] applied_position_o,
    output logic [2:0] applied_resolution_o,
    output logic update_pending_o
);
    import sps_pkg::*;

    // Refuse parameter values the start-up counter cannot serve
    if (START_CYCLES < 1 || START_CYCLES > 65535)
    begin : g_bad_start_cycles
        $error("START_CYCLES out of range");
    end

    sps_mode_type mode; // Power state
    logic [15:0] start_cnt; // Start-up cycles elapsed
    logic step_meta; // Synchroniser first stage
    logic step_sync; // Synchroniser second stage
    logic step_prev; // Delayed copy for edge detection
    logic step_edge; // One-cycle rising edge
    logic [2:0] selected_res; // Resolution chosen now by pins and fields
    logic [5:0] step_inc; // Increment of the applied resolution
    logic [5:0] snap_inc; // Increment of the selected resolution
    logic frozen; // Stall hold freezes the position
    logic pin_update; // Accepted step pulse
    logic host_update; // Accepted host write
    logic any_update; // Any position change command
    logic coarser; // Selected resolution coarser than applied
    logic apply_now; // PWM boundary with pending update
    logic [5:0] base_position; // Position after this cycle's update
    logic [5:0] snapped_position; // Base rounded to selected resolution
    logic [5:0] next_position; // Next value of the counter

    // Maps a resolution code to its step increment
    function automatic logic [5:0] res_increment(input logic [2:0] code);
        logic [5:0] inc;
        inc = `SPS_INC_FULL; // Remaining codes are full step
        case (code)
            `SPS_RES_SIXTEENTH: inc = `SPS_INC_SIXTEENTH; // RULE7
            `SPS_RES_EIGHTH: inc = `SPS_INC_EIGHTH; // RULE7
            `SPS_RES_MINI: inc = `SPS_INC_MINI; // RULE8
            `SPS_RES_HALF: inc = `SPS_INC_HALF; // RULE8
            default: inc = `SPS_INC_FULL; // RULE1
        endcase
        return inc;
    endfunction

    // Power state and start-up timer
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            mode <= SPS_STANDBY;
            start_cnt <= 16'h0000;
        end
        else if (!enable_i)
        begin
            // Standby whenever enable is low
            mode <= SPS_STANDBY; // RULE13
            start_cnt <= 16'h0000;
        end
        else
        begin
            case (mode)
                SPS_STANDBY:
                begin
                    // Begin timing the start-up
                    mode <= SPS_STARTING;
                    start_cnt <= 16'h0000;
                end
                SPS_STARTING:
                begin
                    // Go active once the start-up time is spent
                    if (start_cnt == 16'(START_CYCLES - 1))
                    begin
                        mode <= SPS_ACTIVE; // RULE14
                    end
                    start_cnt <= start_cnt + 16'h0001;
                end
                SPS_ACTIVE:
                begin
                    // Stay active while enabled
                    mode <= SPS_ACTIVE;
                end
                default:
                begin
                    // Recover from an illegal code
                    mode <= SPS_STANDBY;
                end
            endcase
        end
    end

    // Step pin synchroniser and edge history
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            step_meta <= 1'b0;
            step_sync <= 1'b0;
            step_prev <= 1'b0;
        end
        else
        begin
            step_meta <= step_pulse_pin_i; // RULE18
            step_sync <= step_meta;
            step_prev <= step_sync;
        end
    end

    // Update decisions and position arithmetic
    always_comb
    begin
        step_edge = step_sync && !step_prev; // RULE18
        // Aux pin chooses the alternate field only in its resolution function
        if (cfg_i.aux_pin_function == `SPS_AUX_RES_SELECT && aux_input_pin_i)
        begin
            selected_res = cfg_i.alternate_resolution; // RULE6
        end
        else
        begin
            selected_res = cfg_i.primary_resolution; // RULE6
        end
        step_inc = res_increment(applied_resolution_o); // RULE5
        snap_inc = res_increment(selected_res);
        frozen = cfg_i.stall_flag && cfg_i.auto_hold_on_stall; // RULE15
        // Exactly one source may move the position
        pin_update = (mode == SPS_ACTIVE) && cfg_i.step_source_select && step_edge && !frozen; // RULE2 RULE10
        host_update = (mode == SPS_ACTIVE) && !cfg_i.step_source_select && pos_write_i.wr && !frozen; // RULE2 RULE4
        any_update = pin_update || host_update;
        if (pin_update)
        begin
            // Direction bit picks up or down; 6-bit arithmetic wraps
            if (cfg_i.direction)
            begin
                base_position = step_position_o + step_inc; // RULE16 RULE17
            end
            else
            begin
                base_position = step_position_o - step_inc; // RULE16 RULE17
            end
        end
        else if (host_update)
        begin
            base_position = pos_write_i.data; // RULE11
        end
        else
        begin
            base_position = step_position_o;
        end
        coarser = snap_inc > step_inc;
        // Round to nearest multiple of the new increment, ties upward
        snapped_position = (base_position + (snap_inc >> 1)) & ~(snap_inc - 6'h01); // RULE9 RULE17
        apply_now = (mode == SPS_ACTIVE) && pwm_period_start_i && update_pending_o;
        if (apply_now && coarser && !frozen)
        begin
            next_position = snapped_position; // RULE9
        end
        else
        begin
            next_position = base_position;
        end
    end

    // Phase position counter
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            step_position_o <= `SPS_POS_RESET;
        end
        else if (!enable_i || mode != SPS_ACTIVE)
        begin
            // Enable low clears at once, not a cycle behind the mode
            step_position_o <= `SPS_POS_RESET; // RULE13
        end
        else
        begin
            step_position_o <= next_position; // RULE5
        end
    end

    // Pending update flag; a new command wins over the clear
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            update_pending_o <= 1'b0;
        end
        else if (!enable_i || mode != SPS_ACTIVE)
        begin
            // No command survives standby
            update_pending_o <= 1'b0; // RULE13
        end
        else if (any_update)
        begin
            update_pending_o <= 1'b1; // RULE3
        end
        else if (apply_now)
        begin
            update_pending_o <= 1'b0;
        end
    end

    // Values handed to the current profile at the PWM boundary
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            applied_position_o <= `SPS_POS_RESET;
            applied_resolution_o <= `SPS_RES_RESET;
        end
        else if (!enable_i || mode != SPS_ACTIVE)
        begin
            // Profile values return to default with enable low
            applied_position_o <= `SPS_POS_RESET; // RULE13
            applied_resolution_o <= `SPS_RES_RESET;
        end
        else if (apply_now)
        begin
            applied_position_o <= next_position; // RULE3
            applied_resolution_o <= selected_res; // RULE12
        end
    end

    // Active indication
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            active_o <= 1'b0;
        end
        else
        begin
            active_o <= (mode == SPS_STARTING && start_cnt == 16'(START_CYCLES - 1) && enable_i) ||
                        (mode == SPS_ACTIVE && enable_i); // RULE14
        end
    end

endmodule

// ### core/sps_defines.svh
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH

// Width of the phase position counter
`define SPS_POS_W 6
// Reset value of the phase position
`define SPS_POS_RESET 6'h00

// Resolution codes
`define SPS_RES_SIXTEENTH 3'h0
`define SPS_RES_EIGHTH 3'h1
`define SPS_RES_MINI 3'h2
`define SPS_RES_HALF 3'h4
`define SPS_RES_RESET 3'h0

// Increment per step pulse for each resolution
`define SPS_INC_SIXTEENTH 6'h01
`define SPS_INC_EIGHTH 6'h02
`define SPS_INC_MINI 6'h04
`define SPS_INC_HALF 6'h08
`define SPS_INC_FULL 6'h10

// Auxiliary pin function that selects the alternate resolution
`define SPS_AUX_RES_SELECT 2'h1

// Clock rate and start-up time
`define SPS_CLK_MHZ 250
`define SPS_T_START_NS 10000
`define SPS_START_CYCLES ((`SPS_T_START_NS * `SPS_CLK_MHZ + 999) / 1000)

`endif

// ### core/sps_pkg.sv
package sps_pkg;

    // Static configuration and status bits that steer the sequencer
    typedef struct packed {
        logic step_source_select;
        logic [1:0] aux_pin_function;
        logic [2:0] primary_resolution;
        logic [2:0] alternate_resolution;
        logic direction;
        logic auto_hold_on_stall;
        logic stall_flag;
    } sps_cfg_type;

    // Host write of a new phase position
    typedef struct packed {
        logic wr;
        logic [5:0] data;
    } sps_pos_write_type;

    // Power state of the block
    typedef enum logic [1:0] {
        SPS_STANDBY,
        SPS_STARTING,
        SPS_ACTIVE
    } sps_mode_type;

endpackage

// ### test/sps_stepper_phase_sequencer_asserts.sv
`timescale 1ns/100ps
module sps_asserts
    import sps_pkg::*;
#(
    parameter int START_CYCLES = 2500
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic enable_i,
    input wire logic step_pulse_pin_i,
    input wire logic aux_input_pin_i,
    input wire logic pwm_period_start_i,
    input wire sps_pkg::sps_cfg_type cfg_i,
    input wire sps_pkg::sps_pos_write_type pos_write_i,
    input wire logic active_o,
    input wire logic [5:0] step_position_o,
    input wire logic [5:0] applied_position_o,
    input wire logic [2:0] applied_resolution_o,
    input wire logic update_pending_o
);
    // One clock domain, reset disables all checks
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);
    // Frozen on stall, running, and applying at a period start
    wire logic frz = cfg_i.stall_flag & cfg_i.auto_hold_on_stall;
    wire logic run = enable_i & active_o;
    wire logic app = run & pwm_period_start_i & update_pending_o;
    // Resolution the aux pin would pick
    wire logic [2:0] sel_res = (cfg_i.aux_pin_function == 2'h1 && aux_input_pin_i) ?
        cfg_i.alternate_resolution : cfg_i.primary_resolution;
    // Step pin low across the whole sync window
    sequence pin_quiet;
        !step_pulse_pin_i [*4];
    endsequence
    AST_STANDBY: assert property (!enable_i |=> !active_o && step_position_o == 6'h00 &&
        applied_position_o == 6'h00 && applied_resolution_o == 3'h0 && !update_pending_o)
        else $error("standby left state behind");
    AST_STARTUP: assert property ($rose(active_o) |-> $past(enable_i, START_CYCLES + 1))
        else $error("active too early");
    AST_WRITE: assert property (run && pos_write_i.wr && !cfg_i.step_source_select && !frz &&
        !pwm_period_start_i |=> step_position_o == $past(pos_write_i.data) && update_pending_o)
        else $error("host write not taken");
    AST_PIN_IGNORED: assert property (enable_i && !cfg_i.step_source_select && !pos_write_i.wr &&
        !pwm_period_start_i |=> $stable(step_position_o))
        else $error("position moved with pin source off");
    AST_WRITE_LOCKED: assert property (pin_quiet ##0 (enable_i && cfg_i.step_source_select &&
        !pwm_period_start_i) |=> $stable(step_position_o))
        else $error("position moved without a step edge");
    AST_FROZEN: assert property (enable_i && frz |=> $stable(step_position_o))
        else $error("position moved while frozen");
    AST_APPLY_AT_PWM: assert property (enable_i && !pwm_period_start_i |=>
        $stable(applied_position_o) && $stable(applied_resolution_o))
        else $error("applied values moved between periods");
    AST_APPLY: assert property (app |=> applied_resolution_o == $past(sel_res) &&
        (applied_position_o == step_position_o || update_pending_o))
        else $error("period start applied wrong values");
    AST_PEND_CLEAR: assert property (app && !pos_write_i.wr && !cfg_i.step_source_select |=>
        !update_pending_o)
        else $error("pending not cleared");
endmodule
bind sps_stepper_phase_sequencer sps_asserts #(
    .START_CYCLES(START_CYCLES)
) u_sps_asserts (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .enable_i(enable_i),
    .step_pulse_pin_i(step_pulse_pin_i),
    .aux_input_pin_i(aux_input_pin_i),
    .pwm_period_start_i(pwm_period_start_i),
    .cfg_i(cfg_i),
    .pos_write_i(pos_write_i),
    .active_o(active_o),
    .step_position_o(step_position_o),
    .applied_position_o(applied_position_o),
    .applied_resolution_o(applied_resolution_o),
    .update_pending_o(update_pending_o)
);

// ### test/sps_step_source.sv
`timescale 1ns/100ps
module sps_step_source (
    input wire logic ref_clk_i,
    input wire logic fire_i,
    output logic step_pulse_pin_o
);
    // Cycles left in the current pulse
    logic [1:0] hold = 2'h0;
    // Two cycles high per request, low until the next one
    always_ff @(posedge ref_clk_i)
    begin
        if (fire_i)
            hold <= 2'h2;
        else if (hold != 2'h0)
            hold <= hold - 2'h1;
    end
    // Idle low so each request gives one clean rising edge
    assign step_pulse_pin_o = (hold != 2'h0);
endmodule

// ### test/sps_stepper_phase_sequencer_tb_top.sv
`timescale 1ns/100ps
module sps_stepper_phase_sequencer_tb_top;
    import sps_pkg::*;
    // Stimulus, all defined at time zero
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic en = 1'b0;
    logic aux = 1'b0;
    logic pwm = 1'b0;
    logic fire = 1'b0;
    logic pin;
    sps_cfg_type cfg = '0;
    sps_pos_write_type pw = '0;
    // Observed outputs
    logic act;
    logic [5:0] pos;
    logic [5:0] apos;
    logic [2:0] ares;
    logic pend;
    // Score and reference position
    int n_fail = 0;
    int comparisons = 0;
    logic [5:0] exp_pos = 6'h2B;
    logic [5:0] cur_inc = 6'h01;
    sps_stepper_phase_sequencer #(.START_CYCLES(4)) u_sps_stepper_phase_sequencer (.ref_clk_i(ref_clk),
        .rstn_i(rstn), .enable_i(en), .step_pulse_pin_i(pin), .aux_input_pin_i(aux), .pwm_period_start_i(pwm),
        .cfg_i(cfg), .pos_write_i(pw), .active_o(act), .step_position_o(pos), .applied_position_o(apos),
        .applied_resolution_o(ares), .update_pending_o(pend));
    sps_step_source u_sps_step_source (.ref_clk_i(ref_clk), .fire_i(fire), .step_pulse_pin_o(pin));
    // 250 MHz clock
    initial
        forever #2 ref_clk = ~ref_clk;
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Compare one value
    task automatic chk(input logic [5:0] got, input logic [5:0] want);
        comparisons++;
        if (got !== want)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    // Look at outputs half a cycle after the edge that launched them
    task automatic settle();
        @(negedge ref_clk);
    endtask
    // Each driver starts on a rising edge
    task automatic step_pulse();
        tick(1);
        fire <= 1'b1;
        tick(1);
        fire <= 1'b0;
        tick(8);
    endtask
    task automatic pwm_pulse();
        tick(1);
        pwm <= 1'b1;
        tick(1);
        pwm <= 1'b0;
        tick(2);
    endtask
    task automatic host_write(input logic [5:0] d);
        tick(1);
        pw <= {1'b1, d};
        tick(1);
        pw <= '0;
        tick(2);
    endtask
    task automatic t_startup();
        en <= 1'b1;
        tick(4);
        settle();
        chk({5'h0, act}, 6'h00);
        settle();
        chk({5'h0, act}, 6'h01);
        $display("startup test done");
    endtask
    task automatic t_write();
        host_write(6'h2B);
        settle();
        chk(pos, 6'h2B);
        chk(apos, 6'h00);
        pwm_pulse();
        settle();
        chk(apos, 6'h2B);
        chk({5'h0, pend}, 6'h00);
        tick(1);
        cfg.auto_hold_on_stall <= 1'b1;
        cfg.stall_flag <= 1'b1;
        host_write(6'h15);
        settle();
        chk(pos, 6'h2B);
        tick(1);
        cfg.stall_flag <= 1'b0;
        step_pulse();
        settle();
        chk(pos, 6'h2B);
        tick(1);
        cfg.step_source_select <= 1'b1;
        host_write(6'h15);
        settle();
        chk(pos, 6'h2B);
        $display("write test done");
    endtask
    // Step at each resolution, then switch; dir low also uses the aux pin
    task automatic t_steps(input logic dir);
        logic [2:0] code [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h3};
        logic [5:0] inc;
        tick(1);
        cfg.direction <= dir;
        foreach (code[i])
        begin
            cfg.primary_resolution <= dir ? code[i] : 3'h7;
            cfg.alternate_resolution <= code[i];
            step_pulse();
            exp_pos = dir ? exp_pos + cur_inc : exp_pos - cur_inc;
            settle();
            chk(pos, exp_pos);
            pwm_pulse();
            inc = 6'h01 << i;
            if (inc > cur_inc)
                exp_pos = (exp_pos + (inc >> 1)) & ~(inc - 6'h01);
            cur_inc = inc;
            settle();
            chk(pos, exp_pos);
            chk(apos, exp_pos);
            chk({3'h0, ares}, {3'h0, code[i]});
            // Back to a rising edge before the next drive
            tick(1);
        end
        $display("step test done");
    endtask
    task automatic t_standby();
        en <= 1'b0;
        tick(2);
        settle();
        chk(pos, 6'h00);
        chk(apos, 6'h00);
        chk({3'h0, ares}, 6'h00);
        chk({5'h0, pend}, 6'h00);
        chk({5'h0, act}, 6'h00);
        $display("standby test done");
    endtask
    task automatic complete_run();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Hang guard
    initial
    begin
        #40000;
        n_fail++;
        complete_run();
    end
    initial
    begin
        tick(4);
        rstn <= 1'b1;
        t_startup();
        t_write();
        t_steps(1'b1);
        cfg.aux_pin_function <= 2'h1;
        aux <= 1'b1;
        t_steps(1'b0);
        t_standby();
        complete_run();
    end
endmodule
